// [rtl/slt_bridge.sv]
`timescale 1ns/1ps

// ************************************************
// Sample buffer
// ************************************************
module slt_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   input  wire logic             i_sys_clk,  // System clock
   input  wire logic             i_rst,      // Async reset
   input  wire logic             i_wr_valid, // Write offered
   output logic                  o_wr_ready, // Space free
   input  wire logic [WIDTH-1:0] i_wr_data,  // Write word
   output logic                  o_rd_valid, // Word present
   input  wire logic             i_rd_ready, // Reader takes
   output logic      [WIDTH-1:0] o_rd_data   // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   // Refused at elaboration, before any simulation time passes
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("slt_fifo: DEPTH must be a power of two >= 2");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("slt_fifo: WIDTH must be at least one");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             do_wr;
   logic             do_rd;
   logic             full;
   logic             empty;

   assign full       = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty      = (wr_ptr_r == rd_ptr_r);
   assign o_wr_ready = !full;
   assign o_rd_valid = !empty;
   assign do_wr      = i_wr_valid && !full;
   assign do_rd      = i_rd_ready && !empty;
   // Read data comes straight from the array; the reader takes it
   // in the same cycle that it raises ready.
   assign o_rd_data  = mem_r[rd_ptr_r[AW-1:0]];

   // Full refuses the write: oldest words are never overwritten
   always_ff @(posedge i_sys_clk) begin
      if (do_wr) begin
         mem_r[wr_ptr_r[AW-1:0]] <= i_wr_data;  // see R17
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule // slt_fifo

// ************************************************
// Tunnel bridge, deserializer end
// ************************************************
module slt_bridge #(
   parameter int DEPTH = slt_pkg::FIFO_DEPTH
) (
   input  wire logic              i_sys_clk,        // Oscillator clock
   input  wire logic              i_rst,            // Async reset
   input  wire logic              i_pix_clk,        // Recovered pixel clk
   input  wire logic [slt_pkg::MODE_W-1:0] i_fast_ctrl_channel_select,
                                                    // Mode field
   input  wire logic              i_bc_div_sel,     // 1: 10 Mbps
   input  wire logic              i_back_channel_fast_enable, // 20 Mbps
   input  wire logic              i_fwd_sclk_bit,   // Frame clock bit
   input  wire logic              i_fwd_mosi_bit,   // Frame data bit
   input  wire logic              i_fwd_ss_n_bit,   // Frame select bit
   input  wire logic              i_sclk,           // Clock pin in
   output logic                   o_sclk,           // Clock pin out
   output logic                   o_sclk_oe,        // Clock pin drive
   input  wire logic              i_mosi,           // Data pin in
   output logic                   o_mosi,           // Data pin out
   output logic                   o_mosi_oe,        // Data pin drive
   input  wire logic              i_ss_n,           // Select pin in
   output logic                   o_ss_n,           // Select pin out
   output logic                   o_ss_n_oe,        // Select pin drive
   output logic                   o_bc_frame_stb,   // Back frame pulse
   output logic                   o_bc_ss_n,        // Frame select
   output logic                   o_bc_smp_valid,   // Frame has sample
   output logic                   o_bc_mosi,        // Frame sample
   output logic                   o_overflow        // Sample dropped
);
   import slt_pkg::*;

   // ************************************************
   // Elaboration checks
   // ************************************************
   if (DEPTH < 2) begin : g_depth_small
      $error("slt_bridge: DEPTH too small");
   end
   if ((1 << $clog2(DEPTH)) != DEPTH) begin : g_depth_pow2
      $error("slt_bridge: DEPTH must be a power of two");
   end

   // ************************************************
   // Mode decode, system domain
   // ************************************************
   // The tunnel only moves pin traffic; no path reaches local
   // configuration state.  see R16
   slt_mode_t mode_r;
   slt_mode_t mode_nxt;
   logic      rev_en;
   logic      fwd_en;

   // Codes other than the two SPI modes leave the tunnel idle: the
   // pins are released and no back frames go out.
   always_comb begin
      unique case (i_fast_ctrl_channel_select)
         MODE_FWD_SPI: mode_nxt = SLT_FWD;  // see R14
         MODE_REV_SPI: mode_nxt = SLT_REV;  // see R14
         default:      mode_nxt = SLT_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_r <= SLT_IDLE;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   assign rev_en = (mode_r == SLT_REV);
   assign fwd_en = (mode_r == SLT_FWD);

   // ************************************************
   // Forward path, pixel clock domain
   // ************************************************
   // Mode level crosses on two flops; nothing reads the first
   logic fwd_meta_r;
   logic fwd_pix_r;
   logic sclk_d1_r;
   logic sclk_out_r;
   logic mosi_out_r;
   logic ss_out_r;
   logic mosi_nxt;

   always_ff @(posedge i_pix_clk or posedge i_rst) begin
      if (i_rst) begin
         fwd_meta_r <= 1'b0;
         fwd_pix_r  <= 1'b0;
      end else begin
         fwd_meta_r <= fwd_en;
         fwd_pix_r  <= fwd_meta_r;
      end
   end

   // Data launches a cycle ahead of the clock, so the slave sees
   // an extra pixel period of setup.
   assign mosi_nxt = sclk_out_r ? mosi_out_r    // see R4
                                : i_fwd_mosi_bit;

   always_ff @(posedge i_pix_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_d1_r  <= SCLK_IDLE;
         sclk_out_r <= SCLK_IDLE;
         mosi_out_r <= 1'b0;
         ss_out_r   <= SS_IDLE;
      end else if (fwd_pix_r) begin
         sclk_d1_r  <= i_fwd_sclk_bit;     // see R3
         sclk_out_r <= sclk_d1_r;          // see R5
         mosi_out_r <= mosi_nxt;           // see R3
         ss_out_r   <= i_fwd_ss_n_bit;     // see R3
      end else begin
         sclk_d1_r  <= SCLK_IDLE;
         sclk_out_r <= SCLK_IDLE;
         mosi_out_r <= 1'b0;
         ss_out_r   <= SS_IDLE;
      end
   end

   // ************************************************
   // Pin outputs, pixel clock domain
   // ************************************************
   // Drive enables follow the synchronised mode, so the pins are
   // released within two pixel cycles of leaving forward mode.
   assign o_sclk    = sclk_out_r;
   assign o_mosi    = mosi_out_r;
   assign o_ss_n    = ss_out_r;
   assign o_sclk_oe = fwd_pix_r;
   assign o_mosi_oe = fwd_pix_r;
   assign o_ss_n_oe = fwd_pix_r;

   // ************************************************
   // Reverse capture, system domain
   // ************************************************
   // Pins are asynchronous to the oscillator: two flops each
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       sclk_prev_r;
   logic       sclk_s;
   logic       mosi_s;
   logic       ss_n_s;
   logic       sclk_rise;
   logic       cap_valid;
   logic       cap_ready;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_r  <= {SS_IDLE, 1'b0, SCLK_IDLE};
         pin_sync_r  <= {SS_IDLE, 1'b0, SCLK_IDLE};
         sclk_prev_r <= SCLK_IDLE;
      end else begin
         pin_meta_r  <= {i_ss_n, i_mosi, i_sclk};  // see R6
         pin_sync_r  <= pin_meta_r;                // see R6
         sclk_prev_r <= pin_sync_r[0];
      end
   end

   assign sclk_s    = pin_sync_r[0];
   assign mosi_s    = pin_sync_r[1];
   assign ss_n_s    = pin_sync_r[2];
   assign sclk_rise = sclk_s && !sclk_prev_r;
   // Active edge taken as rising while selected
   assign cap_valid = rev_en && !ss_n_s && sclk_rise;  // see R7

   // ************************************************
   // Overflow flag
   // ************************************************
   // A refused write is a lost sample; flag it until reset.
   // A compliant master never gets here with the default depth.
   logic ovf_r;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ovf_r <= 1'b0;
      end else if (cap_valid && !cap_ready) begin
         ovf_r <= 1'b1;                        // see R17
      end
   end

   assign o_overflow = ovf_r;

   // ************************************************
   // Sample buffer
   // ************************************************
   logic             buf_valid;
   logic             buf_ready;
   logic [SMP_W-1:0] buf_data;

   slt_fifo #(
      .WIDTH (SMP_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_wr_valid (cap_valid),     // see R8
      .o_wr_ready (cap_ready),
      .i_wr_data  (mosi_s),
      .o_rd_valid (buf_valid),
      .i_rd_ready (buf_ready),
      .o_rd_data  (buf_data)
   );

   // ************************************************
   // Back-channel frame timing
   // ************************************************
   logic [FRAME_CNT_W-1:0] frame_len;
   logic [FRAME_CNT_W-1:0] frame_cnt_r;
   logic [FRAME_CNT_W-1:0] frame_cnt_nxt;
   logic                   frame_end;

   // Fast enable overrides the divider select
   assign frame_len = i_back_channel_fast_enable ? FRAME_20M_CYC :
                      i_bc_div_sel               ? FRAME_10M_CYC :
                                                   FRAME_5M_CYC;  // see R15
   // Compare with >= so a rate change that shortens the frame
   // ends the current frame at once instead of wrapping round.
   assign frame_end     = (frame_cnt_r >= frame_len - 1'b1);
   assign frame_cnt_nxt = frame_end ? '0 : frame_cnt_r + 1'b1;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         frame_cnt_r <= '0;
      end else begin
         frame_cnt_r <= frame_cnt_nxt;
      end
   end

   // ************************************************
   // Back-channel frame content
   // ************************************************
   // One pop per frame caps the payload at a single sample, and
   // the buffer soaks up bursts between frames.
   assign buf_ready = rev_en && frame_end;   // see R13

   logic frame_go;
   logic stb_r;
   logic bc_ss_r;
   logic bc_vld_r;
   logic bc_mosi_r;
   logic bc_mosi_nxt;

   assign frame_go    = rev_en && frame_end;
   assign bc_mosi_nxt = buf_valid ? buf_data[0] : 1'b0;

   // Strobe runs apart from the payload: it falls back after one
   // cycle while the payload stands until the next frame.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         stb_r <= 1'b0;
      end else begin
         stb_r <= frame_go;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         bc_ss_r   <= SS_IDLE;
         bc_vld_r  <= 1'b0;
         bc_mosi_r <= 1'b0;
      end else if (frame_go) begin
         bc_ss_r   <= ss_n_s;               // see R9
         bc_vld_r  <= buf_valid;            // see R8
         bc_mosi_r <= bc_mosi_nxt;
      end
   end

   assign o_bc_frame_stb = stb_r;
   assign o_bc_ss_n      = bc_ss_r;
   assign o_bc_smp_valid = bc_vld_r;
   assign o_bc_mosi      = bc_mosi_r;

endmodule // slt_bridge

// [rtl/slt_pkg.sv]
// Overview of operation
// R1: Remote master drives clock, data, select
// R2: Remote end oversamples pins with pixel clock
// R3: Forward mode rebuilds pins from frame bits
// R4: Forward data held while clock high
// R5: Forward clock one pixel cycle after data
// R6: Reverse select and clock synchronised locally
// R7: Reverse data captured on active clock edge
// R8: Reverse samples buffered, drained into frames
// R9: Every back frame carries select state
// R10: Master keeps select high one frame
// R11: Remote end may replay data in bursts
// R12: Master waits round trip before sampling
// R13: At most one sample per back frame
// R14: Mode 110 forward, 111 reverse
// R15: Rate 5/10 Mbps, fast enable gives 20
// R16: Tunnel never reaches own configuration
// R17: Buffer deep enough, overflow drops newest
package slt_pkg;

   // ************************************************
   // Mode codes
   // ************************************************
   localparam int           MODE_W       = 3;
   localparam logic [2:0]   MODE_FWD_SPI = 3'h6;
   localparam logic [2:0]   MODE_REV_SPI = 3'h7;

   // ************************************************
   // Timing
   // ************************************************
   localparam int           CLK_PERIOD_PS = 50000;
   localparam int           FRAME_5M_PS   = 7500000;
   localparam int           FRAME_10M_PS  = 3750000;
   localparam int           FRAME_20M_PS  = 1875000;
   localparam int           FRAME_CNT_W   = 8;
   localparam logic [7:0]   FRAME_5M_CYC  =
      8'(FRAME_5M_PS / CLK_PERIOD_PS);
   localparam logic [7:0]   FRAME_10M_CYC =
      8'(FRAME_10M_PS / CLK_PERIOD_PS);
   localparam logic [7:0]   FRAME_20M_CYC =
      8'(FRAME_20M_PS / CLK_PERIOD_PS);

   // ************************************************
   // Buffer and idle levels
   // ************************************************
   localparam int           SMP_W        = 1;
   localparam int           FIFO_DEPTH   = 32;
   localparam logic         SS_IDLE      = 1'b1;
   localparam logic         SCLK_IDLE    = 1'b0;

   typedef enum logic [1:0] {
      SLT_IDLE = 2'b00,
      SLT_FWD  = 2'b01,
      SLT_REV  = 2'b10
   } slt_mode_t;

endpackage

// [test/slt_bridge_monitor.sv]
`timescale 1ns/1ps
// ************************************************
// Port checks
// ************************************************
module slt_bridge_monitor
   import slt_pkg::*;
(
   input wire logic       i_sys_clk,                  // Oscillator clock
   input wire logic       i_rst,                      // Async reset
   input wire logic       i_pix_clk,                  // Pixel clock
   input wire logic [slt_pkg::MODE_W-1:0] i_fast_ctrl_channel_select, // Mode
   input wire logic       i_bc_div_sel,               // 10 Mbps
   input wire logic       i_back_channel_fast_enable, // 20 Mbps
   input wire logic       i_fwd_sclk_bit,             // Frame clock bit
   input wire logic       i_fwd_ss_n_bit,             // Frame select bit
   input wire logic       i_ss_n,                     // Select pin in
   input wire logic       o_sclk,                     // Clock pin out
   input wire logic       o_sclk_oe,                  // Clock pin drive
   input wire logic       o_mosi,                     // Data pin out
   input wire logic       o_ss_n,                     // Select pin out
   input wire logic       o_bc_frame_stb,             // Frame pulse
   input wire logic       o_bc_ss_n,                  // Frame select
   input wire logic       o_overflow                  // Sample dropped
);
   wire rev_w  = i_fast_ctrl_channel_select == MODE_REV_SPI;
   wire fst_w  = rev_w && i_back_channel_fast_enable;
   wire mid_w  = rev_w && !i_back_channel_fast_enable && i_bc_div_sel;
   wire slw_w  = rev_w && !i_back_channel_fast_enable && !i_bc_div_sel;

   a_mosi_hold: assert property (@(posedge i_pix_clk)
      disable iff (i_rst) $past(o_sclk) |-> $stable(o_mosi))
      else $error("data out moved while clock out high");
   a_sel_follow: assert property (@(posedge i_pix_clk)
      disable iff (i_rst) o_sclk_oe && $past(o_sclk_oe)
      |-> o_ss_n == $past(i_fwd_ss_n_bit)) else $error("select out wrong");
   a_clk_delay: assert property (@(posedge i_pix_clk)
      disable iff (i_rst) o_sclk_oe && $past(o_sclk_oe) &&
      $past(o_sclk_oe, 2) |-> o_sclk == $past(i_fwd_sclk_bit, 2))
      else $error("clock out not one cycle behind data");
   a_fwd_idle: assert property (@(posedge i_pix_clk)
      disable iff (i_rst) !o_sclk_oe && !$past(o_sclk_oe)
      |-> !o_sclk && o_ss_n) else $error("pins not idle");
   a_stb_pulse: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_bc_frame_stb |=> !o_bc_frame_stb [*8])
      else $error("frame strobes too close");
   a_rate_fast: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_bc_frame_stb && fst_w ##37 fst_w
      |-> o_bc_frame_stb) else $error("fast frame period wrong");
   a_rate_mid: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_bc_frame_stb && mid_w ##75 mid_w
      |-> o_bc_frame_stb) else $error("mid frame period wrong");
   a_rate_slow: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_bc_frame_stb && slw_w ##150 slw_w
      |-> o_bc_frame_stb) else $error("slow frame period wrong");
   a_no_frames: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) !rev_w && !$past(rev_w) && !$past(rev_w, 2)
      |-> !o_bc_frame_stb) else $error("frame outside reverse mode");
   a_frame_sel: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_bc_frame_stb && $past(i_ss_n, 2) ==
      $past(i_ss_n, 3) && $past(i_ss_n, 3) == $past(i_ss_n, 4)
      |-> o_bc_ss_n == $past(i_ss_n, 3)) else $error("frame select wrong");
   a_ovf_sticky: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) $past(o_overflow) |-> o_overflow)
      else $error("overflow flag cleared");
endmodule // slt_bridge_monitor

bind slt_bridge slt_bridge_monitor u_mon (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pix_clk(i_pix_clk),
   .i_fast_ctrl_channel_select(i_fast_ctrl_channel_select),
   .i_bc_div_sel(i_bc_div_sel),
   .i_back_channel_fast_enable(i_back_channel_fast_enable),
   .i_fwd_sclk_bit(i_fwd_sclk_bit), .i_fwd_ss_n_bit(i_fwd_ss_n_bit),
   .i_ss_n(i_ss_n), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
   .o_mosi(o_mosi), .o_ss_n(o_ss_n), .o_bc_frame_stb(o_bc_frame_stb),
   .o_bc_ss_n(o_bc_ss_n), .o_overflow(o_overflow));

// [test/slt_spi_master_model.sv]
`timescale 1ns/1ps
// ************************************************
// Local master, reverse mode
// ************************************************
module slt_spi_master_model #(
   parameter int GAP_NS = 8000
) (
   input  wire logic       i_go,      // Start one byte
   input  wire logic [7:0] i_byte,    // Byte, sent msb first
   input  int              i_half_ns, // Half clock period
   output logic            o_busy,    // Byte in flight
   output logic            o_sclk,    // Clock pin
   output logic            o_mosi,    // Data pin
   output logic            o_ss_n     // Select pin
);
   initial begin
      o_busy = 1'b0;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
      o_ss_n = 1'b1;
   end
   // Slow half period leaves room for the round trip of a read
   always @(posedge i_go) begin
      o_busy = 1'b1;
      o_ss_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         o_mosi = i_byte[i];
         #(i_half_ns) o_sclk = 1'b1;
         #(i_half_ns) o_sclk = 1'b0;
      end
      o_mosi = ~o_mosi;
      #(i_half_ns) o_ss_n = 1'b1;
      // Select stays high longer than the slowest frame
      #(GAP_NS) o_busy = 1'b0;
   end
endmodule // slt_spi_master_model

// [test/slt_bridge_bench.sv]
`timescale 1ns/1ps
module slt_bridge_bench;
   import slt_pkg::*;
   logic       sys_clk, rst, pix_clk, div, fast, fs, fm, fss, go;
   logic       sclk, mosi, ss_n, busy, osclk, oe, omosi, oss, stb, bss;
   logic       bv, bm, ovf, lo_seen, moe, soe;
   logic [2:0] mode;
   logic [7:0] byte_v;
   int         half, errors, checked, cyc, last, gap, hi;
   logic       q[$];
   logic       expq[$];

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      pix_clk = 1'b0;
      #7;
      forever #62.5 pix_clk = ~pix_clk;
   end

   slt_bridge dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_pix_clk(pix_clk),
      .i_fast_ctrl_channel_select(mode), .i_bc_div_sel(div),
      .i_back_channel_fast_enable(fast), .i_fwd_sclk_bit(fs),
      .i_fwd_mosi_bit(fm), .i_fwd_ss_n_bit(fss), .i_sclk(sclk),
      .o_sclk(osclk), .o_sclk_oe(oe), .i_mosi(mosi), .o_mosi(omosi),
      .o_mosi_oe(moe), .i_ss_n(ss_n), .o_ss_n(oss), .o_ss_n_oe(soe),
      .o_bc_frame_stb(stb), .o_bc_ss_n(bss), .o_bc_smp_valid(bv),
      .o_bc_mosi(bm), .o_overflow(ovf));
   slt_spi_master_model u_master (.i_go(go), .i_byte(byte_v),
      .i_half_ns(half), .o_busy(busy), .o_sclk(sclk), .o_mosi(mosi),
      .o_ss_n(ss_n));

   task automatic test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      checked++;
      if (s !== e) begin
         $display("unexpected %s: expected %0h seen %0h", n, e, s);
         errors++;
      end
   endtask

   // Frame collector; sampled after the edge so the strobe has settled
   always @(posedge sys_clk) begin
      #1;
      cyc++;
      if (cyc > 40000) begin
         errors++;
         test_done();
      end
      if (stb === 1'b1) begin
         gap = cyc - last;
         last = cyc;
         if (bss === 1'b0) lo_seen = 1'b1;
         if (bv === 1'b1) q.push_back(bm);
      end
   end

   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) expq.push_back(b[i]);
      @(posedge sys_clk) #2;
      byte_v = b;
      go = 1'b1;
      @(posedge sys_clk) #2;
      go = 1'b0;
      for (int i = 0; i < 8000 && busy; i++) @(posedge sys_clk);
   endtask

   // Remote frame bits; data flips while the clock bit is still high
   task automatic fstep(input logic s, input logic m, input logic d);
      @(posedge pix_clk) #2;
      if (osclk === 1'b1) begin
         hi++;
         chk("fwd_mosi", d, omosi);
         chk("fwd_ss_n", 0, oss);
      end
      fs = s;
      fm = m;
   endtask

   task automatic t_fwd();
      logic [7:0] b;
      b = 8'ha5;
      mode = MODE_FWD_SPI;
      hi = 0;
      repeat (8) @(posedge pix_clk) #2;
      chk("fwd_oe", 1, oe);
      chk("fwd_mosi_oe", 1, moe);
      chk("fwd_ss_n_oe", 1, soe);
      fss = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fstep(0, b[i], b[i]);
         fstep(1, b[i], b[i]);
         fstep(1, b[i], b[i]);
         fstep(1, ~b[i], b[i]);
         fstep(0, ~b[i], b[i]);
         fstep(0, ~b[i], b[i]);
      end
      chk("fwd_highs", 24, hi);
      fss = 1'b1;
      repeat (4) @(posedge pix_clk) #2;
      mode = 3'h5;
      repeat (8) @(posedge pix_clk) #2;
      chk("idle_oe", 0, oe);
      chk("idle_mosi_oe", 0, moe);
      chk("idle_ss_n_oe", 0, soe);
      chk("idle_ss_n", 1, oss);
   endtask

   task automatic t_rev(input logic f, input logic d, input int len);
      @(posedge sys_clk) #2;
      mode = 3'h0;
      fast = f;
      div = d;
      repeat (4) @(posedge sys_clk) #2;
      mode = MODE_REV_SPI;
      q.delete();
      expq.delete();
      lo_seen = 1'b0;
      repeat (2 * len) @(posedge sys_clk);
      send(8'h3c ^ {f, d, 6'h21});
      repeat (3 * len) @(posedge sys_clk) #2;
      chk("frame_gap", len, gap);
      chk("samples", 8, q.size());
      for (int i = 0; i < 8; i++) chk("sample", expq[i], q[i]);
      chk("sel_low", 1, lo_seen);
      chk("sel_idle", 1, bss);
      chk("no_ovf", 0, ovf);
   endtask

   task automatic t_ovf();
      t_rev(0, 0, 150);
      half = 200;
      for (int i = 0; i < 5; i++) send(8'h5a + 8'(i));
      repeat (6000) @(posedge sys_clk);
      chk("ovf", 1, ovf);
      for (int i = 0; i < 24; i++) chk("oldest", expq[i], q[i]);
   endtask

   initial begin
      {div, fast, fs, fm, go, errors, checked, cyc, last, gap} = '0;
      fss = 1'b1;
      mode = 3'h0;
      byte_v = 8'h00;
      half = 4000;
      rst = 1'b1;
      repeat (2) @(posedge sys_clk) #2;
      rst = 1'b0;
      t_fwd();
      t_rev(0, 0, 150);
      t_rev(0, 1, 75);
      t_rev(1, 0, 37);
      t_ovf();
      test_done();
   end
endmodule // slt_bridge_bench
